// ### design/vipc_ctrl.sv
// event arbitration, vector generation and power-reduction wake logic
`timescale 1ns/10ps
module vipc_ctrl (
  input  wire logic                         mclk_in,
  input  wire logic                         reset_in,
  input  wire logic                         clk_en_in,
  input  wire logic [7:0]                   event_enable_low_reg_in,
  input  wire logic [7:0]                   event_enable_high_reg_in,
  input  wire logic [7:0][7:0]              priority_assign_reg_in,
  input  wire logic [6:0]                   soft_irq_request_reg_in,
  input  wire logic [6:0]                   soft_irq_enable_reg_in,
  input  wire logic [vipc_pkg::NUM_PIN-1:0] ext_irq_pins_n_in,
  input  wire logic [1:0]                   ext_level_mode_in,
  input  wire logic                         timer2_baud_mode_in,
  input  wire vipc_pkg::vipc_periph_s       periph_flags_in,
  input  wire logic [vipc_pkg::NUM_EXC-1:0] exception_req_in,
  input  wire logic                         trap_req_in,
  input  wire logic [3:0]                   trap_num_in,
  input  wire logic [3:0]                   current_priority_in,
  input  wire logic                         idle_req_in,
  input  wire logic                         powerdown_req_in,
  input  wire logic                         grant_ack_in,
  output vipc_pkg::vipc_grant_s             grant_out,
  output vipc_pkg::vipc_pstate_e            power_state_out,
  output logic                              core_clk_en_out,
  output logic                              periph_clk_en_out,
  output logic                              osc_enable_out,
  output logic                              wake_out
);
  import vipc_pkg::*;

  vipc_state_s        st_r;
  vipc_state_s        st_nxt;
  logic [NUM_PIN-1:0] sync_n;
  logic               global_event_enable;
  logic [15:0]        enables;
  logic [NUM_EVT-1:0] evt_req;
  logic [3:0]         evt_lvl [0:NUM_EVT-1];
  logic [3:0]         best_lvl;
  logic [3:0]         best_idx;
  logic [3:0]         swi_lvl;
  logic [2:0]         exc_idx;
  logic               exc_any;
  vipc_grant_s        cand;
  logic               cand_is_evt;
  logic               pd_wake;
  logic               ack_take;
  logic               ext0_req;
  logic               ext1_req;

  vipc_sync u_sync (
    .mclk_in    (mclk_in),
    .reset_in   (reset_in),
    .clk_en_in  (clk_en_in),
    .pins_n_in  (ext_irq_pins_n_in),
    .sync_n_out (sync_n)
  );

  assign global_event_enable = event_enable_low_reg_in[EA_POS];
  assign enables             = {event_enable_high_reg_in, event_enable_low_reg_in};
  assign ack_take            = grant_ack_in && st_r.grant.valid;

  // level mode follows the pin; edge mode uses the latched flag
  assign ext0_req = ext_level_mode_in[0] ? ~sync_n[PIN_EXT0] : st_r.edge_flag[PIN_EXT0];
  assign ext1_req = ext_level_mode_in[1] ? ~sync_n[PIN_EXT1] : st_r.edge_flag[PIN_EXT1];

  always_comb
  begin
    evt_req     = '0;
    evt_req[0]  = ext0_req;
    evt_req[1]  = periph_flags_in.timer0_overflow_flag;
    evt_req[2]  = ext1_req;
    evt_req[3]  = periph_flags_in.timer1_overflow_flag;
    evt_req[4]  = periph_flags_in.timer2_overflow_flag
                | periph_flags_in.timer2_external_flag
                | st_r.edge_flag[PIN_TIMER2_TRIGGER_PIN];
    evt_req[5]  = periph_flags_in.can_irq_flag_reg[CAN_BUFF_POS];
    evt_req[6]  = periph_flags_in.serial_rx_flag;
    evt_req[7]  = periph_flags_in.serial_tx_flag;
    evt_req[8]  = periph_flags_in.spi_event_flag;
    evt_req[9]  = periph_flags_in.can_irq_flag_reg[CAN_FRMERR_POS];
    evt_req[10] = periph_flags_in.can_irq_flag_reg[CAN_MSGERR_POS];
    evt_req[11] = periph_flags_in.can_irq_flag_reg[CAN_TXDONE_POS];
    evt_req[12] = periph_flags_in.can_irq_flag_reg[CAN_RXDONE_POS];
  end

  // per-event effective level: 9..15 when eligible, else 0
  for (genvar i = 0; i < NUM_EVT; i++)
  begin : g_evt
    localparam int SLOT = int'(EVT_SLOT[i]);
    logic [FLD_W-1:0] field;
    assign field = priority_assign_reg_in[SLOT / 2][(SLOT % 2) * FLD_HI_POS +: FLD_W];
    assign evt_lvl[i] = (evt_req[i] && enables[SLOT] && global_event_enable && (field != '0))
                      ? {1'b1, field} : LVL_NONE;
  end

  always_comb
  begin
    best_lvl    = LVL_NONE;
    best_idx    = 4'h0;
    swi_lvl     = LVL_NONE;
    exc_idx     = 3'h0;
    exc_any     = 1'b0;
    cand        = GRANT_RST;
    cand_is_evt = 1'b0;
    // strict compare keeps the lowest index, i.e. the best rank, on a tie
    for (int i = 0; i < NUM_EVT; i++)
    begin
      if (evt_lvl[i] > best_lvl)
      begin
        best_lvl = evt_lvl[i];
        best_idx = 4'(i);
      end
    end
    for (int k = 0; k < NUM_SWI; k++)
    begin
      if (soft_irq_request_reg_in[k] && soft_irq_enable_reg_in[k])
        swi_lvl = 4'(k + 1);
    end
    for (int k = NUM_EXC - 1; k >= 0; k--)
    begin
      if (exception_req_in[k])
      begin
        exc_idx = 3'(k);
        exc_any = 1'b1;
      end
    end
    if (exc_any)
    begin
      cand.valid  = 1'b1;
      cand.vector = VEC_EXC_BASE + {11'h000, exc_idx, 2'b00};
      cand.prio   = LVL_EXC;
    end
    else if (trap_req_in)
    begin
      cand.valid  = 1'b1;
      cand.vector = VEC_SWTRAP_BASE + {10'h000, trap_num_in, 2'b00};
      cand.prio   = LVL_EXC;
    end
    else if (best_lvl > current_priority_in)
    begin
      cand.valid  = 1'b1;
      cand.vector = VEC_EVT_BASE + {10'h000, EVT_SLOT[best_idx], 2'b00};
      cand.prio   = best_lvl;
      cand_is_evt = 1'b1;
    end
    else if (swi_lvl > current_priority_in)
    begin
      cand.valid  = 1'b1;
      cand.vector = VEC_SWI_BASE + {10'h000, swi_lvl - 4'h1, 2'b00};
      cand.prio   = swi_lvl;
    end
  end

  // only enabled, level-sensitive external pins may restart the oscillator
  assign pd_wake = global_event_enable
                 && ((enables[EN_EXT0_POS] && ext_level_mode_in[0] && !sync_n[PIN_EXT0])
                  || (enables[EN_EXT1_POS] && ext_level_mode_in[1] && !sync_n[PIN_EXT1]));

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.wake = 1'b0;
    unique case (st_r.pstate)
      PS_RUN:
      begin
        if (powerdown_req_in)
        begin
          st_nxt.pstate        = PS_PDOWN;
          st_nxt.osc_en        = 1'b0;
          st_nxt.core_clk_en   = 1'b0;
          st_nxt.periph_clk_en = 1'b0;
        end
        else if (idle_req_in)
        begin
          st_nxt.pstate        = PS_IDLE;
          st_nxt.core_clk_en   = 1'b0;
          st_nxt.periph_clk_en = 1'b1;
        end
      end
      PS_IDLE:
      begin
        if (cand.valid)
        begin
          st_nxt.pstate      = PS_RUN;
          st_nxt.core_clk_en = 1'b1;
          st_nxt.wake        = 1'b1;
        end
      end
      PS_PDOWN:
      begin
        if (pd_wake)
        begin
          st_nxt.pstate        = PS_RUN;
          st_nxt.osc_en        = 1'b1;
          st_nxt.core_clk_en   = 1'b1;
          st_nxt.periph_clk_en = 1'b1;
          st_nxt.wake          = 1'b1;
        end
      end
      // the unused code recovers to run with every clock on
      default:
      begin
        st_nxt.pstate        = PS_RUN;
        st_nxt.osc_en        = 1'b1;
        st_nxt.core_clk_en   = 1'b1;
        st_nxt.periph_clk_en = 1'b1;
      end
    endcase
    // power-down freezes flags and grant; only the wake path stays live
    if (st_r.pstate != PS_PDOWN)
    begin
      st_nxt.pin_prev = sync_n;
      for (int j = 0; j < NUM_PIN; j++)
      begin
        logic set_f;
        logic clr_f;
        set_f = st_r.pin_prev[j] && !sync_n[j];
        clr_f = ack_take && st_r.src_is_evt;
        if (j == PIN_EXT0)
        begin
          set_f = set_f && !ext_level_mode_in[0];
          clr_f = clr_f && (st_r.src_evt == EVT_EXT0);
        end
        else if (j == PIN_EXT1)
        begin
          set_f = set_f && !ext_level_mode_in[1];
          clr_f = clr_f && (st_r.src_evt == EVT_EXT1);
        end
        else
        begin
          set_f = set_f && timer2_baud_mode_in;
          clr_f = clr_f && (st_r.src_evt == EVT_TMR2);
        end
        // a new edge in the acknowledge cycle survives the clear
        st_nxt.edge_flag[j] = set_f || (st_r.edge_flag[j] && !clr_f);
      end
      // one quiet cycle after an acknowledge avoids a double take
      if (ack_take)
        st_nxt.grant.valid = 1'b0;
      else
      begin
        st_nxt.grant      = cand;
        st_nxt.src_is_evt = cand_is_evt;
        st_nxt.src_evt    = best_idx;
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      st_r <= STATE_RST;
    else if (clk_en_in)
      st_r <= st_nxt;
  end

  assign grant_out         = st_r.grant;
  assign power_state_out   = st_r.pstate;
  assign core_clk_en_out   = st_r.core_clk_en;
  assign periph_clk_en_out = st_r.periph_clk_en;
  assign osc_enable_out    = st_r.osc_en;
  assign wake_out          = st_r.wake;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  a_pd_osc_off: assert property (st_r.pstate == PS_PDOWN |-> !osc_enable_out && !core_clk_en_out)
    else $error("oscillator running in power-down");
  a_idle_clocks: assert property (st_r.pstate == PS_IDLE |-> periph_clk_en_out && !core_clk_en_out)
    else $error("idle clocks wrong");
  a_pd_wake_exit: assert property (st_r.pstate == PS_PDOWN && clk_en_in && pd_wake
    |=> st_r.pstate == PS_RUN && wake_out && osc_enable_out)
    else $error("power-down did not wake");
  a_pd_hold_state: assert property (st_r.pstate == PS_PDOWN && !pd_wake
    |=> $stable(grant_out) && $stable(st_r.edge_flag))
    else $error("state changed in power-down");
  a_swi_level: assert property (grant_out.valid && grant_out.vector >= VEC_SWI_BASE
    |-> grant_out.prio >= 4'h1 && grant_out.prio <= 4'h7)
    else $error("software interrupt level out of range");
  a_evt_level: assert property (grant_out.valid && grant_out.vector >= VEC_EVT_BASE
    && grant_out.vector < VEC_SWI_BASE |-> grant_out.prio >= 4'h9)
    else $error("event level below nine");
  a_evt_preempt: assert property (clk_en_in && st_r.pstate != PS_PDOWN && !ack_take && !exc_any
    && !trap_req_in && best_lvl > current_priority_in |=> grant_out.valid && grant_out.prio == $past(best_lvl))
    else $error("higher event not taken");
  a_global_mask: assert property (clk_en_in && st_r.pstate != PS_PDOWN && !global_event_enable
    && !exc_any && !trap_req_in && swi_lvl == LVL_NONE |=> !grant_out.valid)
    else $error("event passed with global enable clear");
  a_reset_vector: assert property (clk_en_in && st_r.pstate != PS_PDOWN && !ack_take
    && exception_req_in[0] |=> grant_out.valid && grant_out.vector == VEC_EXC_BASE)
    else $error("reset exception not vectored at zero");
  a_ack_quiet: assert property (clk_en_in && st_r.pstate != PS_PDOWN && ack_take
    |=> !grant_out.valid)
    else $error("grant held across acknowledge");
  a_ce_freeze: assert property (!clk_en_in |=> $stable(grant_out) && $stable(power_state_out)
    && $stable(wake_out))
    else $error("state moved while clock enable low");
  a_trap_block: assert property (clk_en_in && st_r.pstate != PS_PDOWN && !ack_take && !exc_any
    && trap_req_in |=> grant_out.valid && grant_out.vector[15:6] == VEC_SWTRAP_BASE[15:6])
    else $error("software trap outside its vector block");

  c_evt_tie: cover property (evt_lvl[0] != LVL_NONE && evt_lvl[0] == evt_lvl[1] && grant_out.valid);
  c_swi_grant: cover property (grant_out.valid && grant_out.vector >= VEC_SWI_BASE);
  c_idle_wake: cover property (st_r.pstate == PS_IDLE ##1 wake_out);
  c_pd_wake: cover property (st_r.pstate == PS_PDOWN ##1 st_r.pstate == PS_RUN);

endmodule : vipc_ctrl

// ### design/vipc_pkg.sv
// package of constants and types for the vectored interrupt priority controller
// Notes on behaviour
// - Idle stops the core clock but keeps peripheral clocks running for wake-up.
// - Power-down stops the oscillator and freezes flags and grant; the pin synchroniser keeps running.
// - Power-down exits on reset or an enabled, level-sensitive external interrupt.
// - Software interrupts run below every event level, letting lower events in.
// - Forty-two vectors: 13 events, 7 software, 16 traps, 6 exceptions.
// - An event above the running priority preempts and is taken at once.
// - Among pending events the highest priority wins.
// - Equal priorities are resolved by fixed rank, lower rank wins.
// - Each event has its own enable bit in the low or high enable register.
// - Global enable in bit 7 of the low enable register gates all events.
// - Each event has a 3-bit priority field; zero disables the event.
// - Event fields map to levels 9..15; software 1..7; 8 unused; 0 off.
// - Reset vectors at zero with rank 0; traps share rank 1 in a block.
// - Exceptions are non-maskable and ignore every enable bit.
// - Event vectors are four-byte slots 0..15, skipping 6, 7 and 10, ranked 2 to 17.
// - CAN flag register bits raise five separate event requests.
// - Timer 2 requests on overflow or external flag; trigger pin in baud mode.
// - Seven software interrupts with request and enable bits, fixed levels.
package vipc_pkg;

  localparam int NUM_EVT  = 13;
  localparam int NUM_SWI  = 7;
  localparam int NUM_TRAP = 16;
  localparam int NUM_EXC  = 6;
  localparam int NUM_VEC  = NUM_EVT + NUM_SWI + NUM_TRAP + NUM_EXC;
  localparam int NUM_PIN  = 3;

  // synchronised pin positions
  localparam int PIN_EXT0 = 0;
  localparam int PIN_EXT1 = 1;
  localparam int PIN_TIMER2_TRIGGER_PIN = 2;

  // event indices that own an edge flag
  localparam logic [3:0] EVT_EXT0 = 4'h0;
  localparam logic [3:0] EVT_EXT1 = 4'h2;
  localparam logic [3:0] EVT_TMR2 = 4'h4;

  localparam int EA_POS       = 7;
  localparam int EN_EXT0_POS  = 0;
  localparam int EN_EXT1_POS  = 2;
  localparam int FLD_LO_POS   = 0;
  localparam int FLD_HI_POS   = 4;
  localparam int FLD_W        = 3;

  localparam int CAN_RXDONE_POS = 0;
  localparam int CAN_TXDONE_POS = 1;
  localparam int CAN_BUFF_POS   = 2;
  localparam int CAN_MSGERR_POS = 3;
  localparam int CAN_FRMERR_POS = 4;

  // slot = enable bit in {high,low}, priority field index, vector slot; rank is slot + 2
  localparam logic [3:0] EVT_SLOT [0:NUM_EVT-1] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                                                    4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};

  localparam logic [15:0] VEC_EXC_BASE    = 16'h0000;
  localparam logic [15:0] VEC_SWTRAP_BASE = 16'h0040;
  localparam logic [15:0] VEC_EVT_BASE    = 16'h0080;
  localparam logic [15:0] VEC_SWI_BASE    = 16'h0100;

  localparam logic [3:0] LVL_EXC   = 4'hF;
  localparam logic [3:0] LVL_NONE  = 4'h0;

  typedef enum logic [1:0] {PS_RUN, PS_IDLE, PS_PDOWN} vipc_pstate_e;

  typedef struct packed {
    logic [4:0] can_irq_flag_reg;
    logic       spi_event_flag;
    logic       serial_tx_flag;
    logic       serial_rx_flag;
    logic       timer2_external_flag;
    logic       timer2_overflow_flag;
    logic       timer1_overflow_flag;
    logic       timer0_overflow_flag;
  } vipc_periph_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] vector;
    logic [3:0]  prio;
  } vipc_grant_s;

  typedef struct packed {
    vipc_pstate_e       pstate;
    logic [NUM_PIN-1:0] pin_prev;
    logic [NUM_PIN-1:0] edge_flag;
    vipc_grant_s        grant;
    logic               src_is_evt;
    logic [3:0]         src_evt;
    logic               core_clk_en;
    logic               periph_clk_en;
    logic               osc_en;
    logic               wake;
  } vipc_state_s;

  localparam vipc_grant_s GRANT_RST = '{valid: 1'b0, vector: 16'h0000, prio: 4'h0};

  localparam vipc_state_s STATE_RST = '{pstate: PS_RUN, pin_prev: 3'h7, edge_flag: 3'h0,
                                        grant: GRANT_RST, src_is_evt: 1'b0, src_evt: 4'h0,
                                        core_clk_en: 1'b1, periph_clk_en: 1'b1,
                                        osc_en: 1'b1, wake: 1'b0};

  localparam logic [NUM_PIN-1:0] SYNC_RST = 3'h7;

endpackage : vipc_pkg

// ### design/vipc_sync.sv
// two-flop synchroniser for the active-low external interrupt pins
`timescale 1ns/10ps
module vipc_sync (
  input  wire logic                        mclk_in,
  input  wire logic                        reset_in,
  input  wire logic                        clk_en_in,
  input  wire logic [vipc_pkg::NUM_PIN-1:0] pins_n_in,
  output logic      [vipc_pkg::NUM_PIN-1:0] sync_n_out
);
  import vipc_pkg::*;

  typedef struct packed {
    logic [NUM_PIN-1:0] meta;
    logic [NUM_PIN-1:0] sync;
  } vipc_sync_s;

  vipc_sync_s st_r;
  vipc_sync_s st_nxt;

  // meta is seen only by the second stage
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.meta = pins_n_in;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      st_r <= '{meta: SYNC_RST, sync: SYNC_RST};
    else if (clk_en_in)
      st_r <= st_nxt;
  end

  assign sync_n_out = st_r.sync;

endmodule : vipc_sync

// ### tb/vipc_core_model.sv
// core-side model that takes grants and tracks the running priority
`timescale 1ns/10ps
module vipc_core_model (
  input  wire logic                  mclk_in,
  input  wire logic                  reset_in,
  input  wire logic                  ack_en_in,
  input  wire vipc_pkg::vipc_grant_s grant_in,
  output logic                       ack_out,
  output logic [3:0]                 cur_prio_out
);
  import vipc_pkg::*;

  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      ack_out      <= 1'b0;
      cur_prio_out <= 4'h0;
    end
    else if (ack_en_in && grant_in.valid && !ack_out)
    begin
      // taking a grant lifts the running level to the grant's own
      ack_out      <= 1'b1;
      cur_prio_out <= grant_in.prio;
    end
    else
      ack_out <= 1'b0;
  end
endmodule : vipc_core_model

// ### tb/vipc_ctrl_tb.sv
// self-checking testbench for the interrupt arbitration and power controller
`timescale 1ns/10ps
module vipc_ctrl_tb;
  import vipc_pkg::*;
  localparam int FS [12] = '{1, 3, 4, 4, 8, 9, 11, 15, 14, 5, 13, 12};
  logic            mclk_in, reset_in, baud, trq, idle, pd, ack, ack_en, cce, pce, osc, wake, ce;
  logic [7:0]      enl, enh;
  logic [7:0][7:0] pa;
  logic [6:0]      soft_irq_request_reg, soft_irq_enable_reg;
  logic [2:0]      pins;
  logic [1:0]      lvl;
  logic [5:0]      exc;
  logic [3:0]      tnum, cur;
  vipc_periph_s    pf;
  vipc_grant_s     grant;
  vipc_pstate_e    pst;
  int              n_errors, n_compared;

  vipc_ctrl dut_u (
    .mclk_in                  (mclk_in),
    .reset_in                 (reset_in),
    .clk_en_in                (ce),
    .event_enable_low_reg_in  (enl),
    .event_enable_high_reg_in (enh),
    .priority_assign_reg_in   (pa),
    .soft_irq_request_reg_in  (soft_irq_request_reg),
    .soft_irq_enable_reg_in   (soft_irq_enable_reg),
    .ext_irq_pins_n_in        (pins),
    .ext_level_mode_in        (lvl),
    .timer2_baud_mode_in      (baud),
    .periph_flags_in          (pf),
    .exception_req_in         (exc),
    .trap_req_in              (trq),
    .trap_num_in              (tnum),
    .current_priority_in      (cur),
    .idle_req_in              (idle),
    .powerdown_req_in         (pd),
    .grant_ack_in             (ack),
    .grant_out                (grant),
    .power_state_out          (pst),
    .core_clk_en_out          (cce),
    .periph_clk_en_out        (pce),
    .osc_enable_out           (osc),
    .wake_out                 (wake)
  );

  vipc_core_model core_u (
    .mclk_in      (mclk_in),
    .reset_in     (reset_in),
    .ack_en_in    (ack_en),
    .grant_in     (grant),
    .ack_out      (ack),
    .cur_prio_out (cur)
  );

  always #2.5 mclk_in = ~mclk_in;

  task automatic summarize();
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : step

  // grant is registered, so two edges cover launch and update
  task automatic gchk(input logic [15:0] v, input logic [3:0] p);
    step(2);
    chk(grant, {1'b1, v, p});
  endtask : gchk

  task automatic gnone();
    step(2);
    chk(grant.valid, 1'b0);
  endtask : gnone

  task automatic wait_run();
    int i;
    // look only after an edge, so a state launched at this edge is never read early
    for (i = 0; i < 20; i++)
    begin
      step(1);
      if (pst === PS_RUN)
        break;
    end
    if (pst !== PS_RUN)
    begin
      n_errors++;
      summarize();
    end
    chk(wake, 1'b1);
  endtask : wait_run

  task automatic do_reset();
    @(posedge mclk_in);
    reset_in <= 1'b1;
    {enl, enh, pa, soft_irq_request_reg, soft_irq_enable_reg, lvl, baud, pf, exc, trq, tnum, idle, pd, ack_en} <= '0;
    pins <= '1;
    ce   <= 1'b1;
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
  endtask : do_reset

  task automatic t_exc();
    do_reset();
    for (int k = 0; k < 6; k++)
    begin
      @(posedge mclk_in);
      exc  <= 6'h3F << k;
      trq  <= 1'b1;
      tnum <= 4'hF;
      gchk(16'(4 * k), 4'hF);
    end
    @(posedge mclk_in);
    exc <= '0;
    for (int n = 0; n < 16; n++)
    begin
      @(posedge mclk_in);
      tnum <= 4'(n);
      gchk(16'h0040 + 16'(4 * n), 4'hF);
    end
  endtask : t_exc

  task automatic t_evt();
    logic [7:0][7:0] fld;
    do_reset();
    for (int b = 0; b < 12; b++)
    begin
      fld = '0;
      fld[FS[b] / 2][(FS[b] % 2) * 4 +: 3] = 3'(b % 7 + 1);
      @(posedge mclk_in);
      enl <= 8'hBF;
      enh <= 8'hFB;
      pa  <= fld;
      pf  <= vipc_periph_s'(12'h001 << b);
      gchk(16'h0080 + 16'(4 * FS[b]), 4'(9 + b % 7));
    end
    @(posedge mclk_in);
    enl <= 8'h3F;
    gnone();
    @(posedge mclk_in);
    enl <= 8'hBF;
    enh <= 8'hEF;
    gnone();
    @(posedge mclk_in);
    enh <= 8'hFB;
    pa  <= '0;
    gnone();
  endtask : t_evt

  task automatic t_pin();
    do_reset();
    @(posedge mclk_in);
    enl  <= 8'h95;
    pa   <= {40'h0, 8'h02, 8'h00, 8'h03};
    baud <= 1'b1;
    pins <= 3'b011;
    step(3);
    gchk(16'h0090, 4'hA);
    @(posedge mclk_in);
    pins <= 3'b010;
    step(3);
    gchk(16'h0080, 4'hB);
  endtask : t_pin

  task automatic t_rank();
    do_reset();
    @(posedge mclk_in);
    enl <= 8'h8A;
    pa  <= {48'h0, 8'h50, 8'h50};
    pf  <= vipc_periph_s'(12'h003);
    soft_irq_request_reg <= 7'h7F;
    soft_irq_enable_reg <= 7'h7F;
    gchk(16'h0084, 4'hD);
    @(posedge mclk_in);
    pa <= {48'h0, 8'h60, 8'h50};
    gchk(16'h008C, 4'hE);
    @(posedge mclk_in);
    pa <= {56'h0, 8'h10};
    gchk(16'h0084, 4'h9);
    @(posedge mclk_in);
    pa <= '0;
    gchk(16'h0118, 4'h7);
    for (int k = 0; k < 7; k++)
    begin
      @(posedge mclk_in);
      soft_irq_request_reg <= 7'h01 << k;
      gchk(16'h0100 + 16'(4 * k), 4'(k + 1));
    end
    @(posedge mclk_in);
    soft_irq_enable_reg <= '0;
    gnone();
  endtask : t_rank

  // core takes the first grant, then a lower and a higher request follow
  task automatic t_pre();
    do_reset();
    @(posedge mclk_in);
    enl    <= 8'h8A;
    pa     <= {48'h0, 8'h10, 8'h20};
    pf     <= vipc_periph_s'(12'h001);
    ack_en <= 1'b1;
    step(4);
    @(posedge mclk_in);
    ack_en <= 1'b0;
    gnone();
    @(posedge mclk_in);
    pf <= vipc_periph_s'(12'h003);
    gnone();
    @(posedge mclk_in);
    pa <= {48'h0, 8'h30, 8'h20};
    gchk(16'h008C, 4'hB);
  endtask : t_pre

  // ext1 edge flag is cleared by the acknowledge; a low clock enable freezes the pin path
  task automatic t_ack();
    do_reset();
    @(posedge mclk_in);
    enl  <= 8'h84;
    pa   <= {48'h0, 8'h01, 8'h00};
    pins <= 3'b101;
    step(3);
    gchk(16'h0088, 4'h9);
    @(posedge mclk_in);
    pins   <= 3'b111;
    ack_en <= 1'b1;
    step(3);
    @(posedge mclk_in);
    ack_en <= 1'b0;
    pa     <= {48'h0, 8'h07, 8'h00};
    gnone();
    @(posedge mclk_in);
    ce   <= 1'b0;
    pins <= 3'b101;
    step(6);
    chk(grant.valid, 1'b0);
    @(posedge mclk_in);
    ce <= 1'b1;
    step(3);
    gchk(16'h0088, 4'hF);
  endtask : t_ack

  task automatic t_pwr();
    do_reset();
    @(posedge mclk_in);
    enl <= 8'h81;
    pd  <= 1'b1;
    @(posedge mclk_in);
    pd <= 1'b0;
    step(1);
    chk({pst, osc, cce, pce}, {PS_PDOWN, 3'b000});
    @(posedge mclk_in);
    pins <= 3'b110;
    step(6);
    chk(pst, PS_PDOWN);
    @(posedge mclk_in);
    lvl <= 2'b01;
    wait_run();
    chk({osc, cce, pce}, 3'b111);
    // second entry: ext1 held low in level mode wakes two edges later
    @(posedge mclk_in);
    enl  <= 8'h84;
    lvl  <= 2'b10;
    pins <= 3'b101;
    pd   <= 1'b1;
    @(posedge mclk_in);
    pd <= 1'b0;
    wait_run();
    chk({pst, osc, cce, pce}, {PS_RUN, 3'b111});
    do_reset();
    @(posedge mclk_in);
    enl  <= 8'h82;
    pa   <= {56'h0, 8'h10};
    idle <= 1'b1;
    @(posedge mclk_in);
    idle <= 1'b0;
    step(1);
    chk({pst, cce, pce}, {PS_IDLE, 2'b01});
    @(posedge mclk_in);
    pf <= vipc_periph_s'(12'h001);
    wait_run();
    chk(grant, {1'b1, 16'h0084, 4'h9});
  endtask : t_pwr

  initial
  begin
    {enl, enh, pa, soft_irq_request_reg, soft_irq_enable_reg, lvl, baud, pf, exc, trq, tnum, idle, pd, ack_en} = '0;
    pins     = '1;
    ce       = 1'b1;
    mclk_in  = 1'b0;
    reset_in = 1'b1;
    t_exc();
    t_evt();
    t_pin();
    t_rank();
    t_pre();
    t_ack();
    t_pwr();
    summarize();
  end
endmodule : vipc_ctrl_tb
